// ===== include/sleep_clock_gate_pkg.sv
package sleep_clock_gate_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses within the system-control window)
  // ---------------------------------------------------------------
  localparam logic [31:0] SYSCTL_BASE = 32'h400fe000;
  localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h110;
  localparam logic [11:0] RUN_CONFIG_OFFSET = 12'h200;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WATCHDOG_BIT = 3;
  localparam int CONVERTER_BIT = 16;
  localparam int PWM_BIT = 20;
  localparam int RATE_LSB = 8;
  localparam int RATE_MSB = 9;
  localparam int AUTO_GATE_BIT = 0;
  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [31:0] SLEEP_GATE_RESET = 32'h00000040;
  localparam logic [31:0] SLEEP_GATE_WMASK = 32'h00110308;
  localparam logic [31:0] RUN_CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] RUN_CONFIG_WMASK = 32'h00000001;
  // ---------------------------------------------------------------
  // Rate codes and bus answers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_125K = 2'h0,
    RATE_250K = 2'h1,
    RATE_500K = 2'h2
  } rate_code_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/sleep_clock_gating_ctrl0.sv
`timescale 1ns/1ps
// Summary of operation
// - Each enable bit gates one unit's clock
// - Access to gated-off unit returns bus fault
// - Enables reset zero; register resets to 0x40
// - This register governs clocking during sleep
// - Sleep settings used only with auto gating set
// - Bits 9:8 select converter sample rate
// - Bit 3 enables watchdog clock, resets zero
// - Reserved bits read reset value (bit 6 one), software preserves them
// - Register at offset 0x110, read/write word
module sleep_clock_gating_ctrl0
  import sleep_clock_gate_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_active,
  input wire logic [2:0] run_gate_en,
  input wire logic [2:0] periph_sel,
  output logic [2:0] periph_fault,
  output logic watchdog_clk_en,
  output logic converter_clk_en,
  output logic pwm_clk_en,
  output logic [1:0] converter_rate_select
);
  // ---------------------------------------------------------------
  // Write channel state
  // ---------------------------------------------------------------
  logic aw_full, next_aw_full;
  logic [11:0] aw_addr, next_aw_addr;
  logic w_full, next_w_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic [31:0] sleep_gate_0, next_sleep_gate_0;
  logic [31:0] run_config, next_run_config;
  logic [31:0] byte_mask;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // Both halves are held so address and data may arrive in either order
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_sleep_gate_0 = sleep_gate_0;
    next_run_config = run_config;
    byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      // Only writable bits change; reserved bits keep their value
      if (aw_addr == SLEEP_GATE_OFFSET) begin
        next_sleep_gate_0 = (sleep_gate_0 & ~(SLEEP_GATE_WMASK & byte_mask)) |
                            (w_data & SLEEP_GATE_WMASK & byte_mask);
      end else if (aw_addr == RUN_CONFIG_OFFSET) begin
        next_run_config = (run_config & ~(RUN_CONFIG_WMASK & byte_mask)) |
                          (w_data & RUN_CONFIG_WMASK & byte_mask);
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      aw_addr <= 12'h000;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      sleep_gate_0 <= SLEEP_GATE_RESET;
      run_config <= RUN_CONFIG_RESET;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      sleep_gate_0 <= next_sleep_gate_0;
      run_config <= next_run_config;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr[11:0] == SLEEP_GATE_OFFSET) begin
        next_rdata = sleep_gate_0;
      end else if (s_axi_araddr[11:0] == RUN_CONFIG_OFFSET) begin
        next_rdata = run_config;
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ---------------------------------------------------------------
  // Clock gating and bus fault
  // ---------------------------------------------------------------
  logic use_sleep;
  logic [2:0] sleep_en;

  // Run enables apply outside sleep, so leaving sleep never stalls a unit
  assign use_sleep = sleep_active && run_config[AUTO_GATE_BIT];
  assign sleep_en = {sleep_gate_0[PWM_BIT], sleep_gate_0[CONVERTER_BIT],
                     sleep_gate_0[WATCHDOG_BIT]};
  assign watchdog_clk_en = use_sleep ? sleep_en[0] : run_gate_en[0];
  assign converter_clk_en = use_sleep ? sleep_en[1] : run_gate_en[1];
  assign pwm_clk_en = use_sleep ? sleep_en[2] : run_gate_en[2];
  assign periph_fault = periph_sel &
                        ~{pwm_clk_en, converter_clk_en, watchdog_clk_en};
  // No clamp on code 3: keeping within the device maximum is up to software
  assign converter_rate_select = sleep_gate_0[RATE_MSB:RATE_LSB];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_gate_write;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[11:0] == SLEEP_GATE_OFFSET &&
    s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hf;
  endsequence

  sequence s_gate_done;
    s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endsequence

  a_sleep_gate_used: assert property (use_sleep |-> watchdog_clk_en == sleep_gate_0[3])
    else $error("watchdog enable does not follow sleep register");
  a_run_gate_used: assert property (!(sleep_active && run_config[0]) |->
    {pwm_clk_en, converter_clk_en, watchdog_clk_en} == run_gate_en)
    else $error("run enables not used outside auto gated sleep");
  a_sleep_mode_select: assert property (sleep_active && run_config[0] |->
    {pwm_clk_en, converter_clk_en} == {sleep_gate_0[20], sleep_gate_0[16]})
    else $error("sleep enables not used in sleep");
  // Fault is judged from the register and run enables, not from the gated outputs
  a_gated_access_fault: assert property (periph_sel != 3'h0 |->
    periph_fault == (periph_sel & ~(use_sleep ? {sleep_gate_0[PWM_BIT],
      sleep_gate_0[CONVERTER_BIT], sleep_gate_0[WATCHDOG_BIT]} : run_gate_en)))
    else $error("access to gated unit did not fault");
  a_reset_value: assert property (!$past(resetn) |-> sleep_gate_0 == SLEEP_GATE_RESET)
    else $error("register reset value wrong");
  a_rate_field: assert property (converter_rate_select == sleep_gate_0[9:8])
    else $error("rate select does not track bits 9:8");
  a_reserved_hold: assert property ((sleep_gate_0 & ~SLEEP_GATE_WMASK) == SLEEP_GATE_RESET)
    else $error("reserved bits changed");
  // Take edge, then register update edge, then the answer is seen standing
  a_write_lands: assert property (s_gate_write |-> ##2 s_gate_done ##0
    sleep_gate_0 == (($past(sleep_gate_0) & ~SLEEP_GATE_WMASK) |
                     ($past(s_axi_wdata, 2) & SLEEP_GATE_WMASK)))
    else $error("full word write to gate register lost");
  a_watchdog_bit: assert property (s_gate_write ##2 use_sleep |->
    watchdog_clk_en == $past(s_axi_wdata[3], 2))
    else $error("watchdog bit write does not reach its clock");
endmodule

// ===== verification/periph_side.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side unit access source
// ------------------------------------------------------------
module periph_side (
  input wire logic mclk,
  input wire logic go,
  input wire logic [1:0] unit,
  output logic [2:0] periph_sel
);
  // One-cycle decode strobe, as a bus hit on one unit would give
  always_ff @(posedge mclk) begin
    periph_sel <= go ? (3'h1 << unit) : 3'h0;
  end
endmodule

// ===== verification/sleep_clock_gating_ctrl0_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module sleep_clock_gating_ctrl0_bench;
  import sleep_clock_gate_pkg::*;
  logic mclk, resetn = 1'b0, go = 1'b0, sleep_active = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, run_gate_en = 3'h5;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] unit = 2'h0;
  logic [31:0] s_axi_rdata, d;
  logic [2:0] periph_sel, periph_fault;
  logic [1:0] s_axi_bresp, s_axi_rresp, converter_rate_select, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic watchdog_clk_en, converter_clk_en, pwm_clk_en;
  int mismatches = 0, cmp_count = 0;
  wire [2:0] ens = {pwm_clk_en, converter_clk_en, watchdog_clk_en};
  sleep_clock_gating_ctrl0 uut (.*);
  periph_side ps (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      mismatches++;
      $display("MISMATCH %0t bus wait ran out", $time);
      conclude;
    end
  endtask
  // Each bus task ends one edge late so no strobe is driven twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
    @(posedge mclk);
  endtask
  task automatic acc(input logic [1:0] u, input logic e);
    go <= 1'b1;
    unit <= u;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    chk(32'(periph_fault), 32'(e) << u);
    @(posedge mclk);
  endtask
  task automatic t_reset;
    rd(12'h110);
    chk(d, 32'h00000040);
    rd(12'h200);
    chk(d, 32'h0);
    chk(32'(ens), 32'h5);
    $display("t_reset done");
  endtask
  task automatic t_gating;
    wr(12'h110, 32'hfffffeff, 4'hf);
    chk(32'(r), 32'(RESP_OKAY));
    rd(12'h110);
    chk(d, 32'h00110248);
    chk(32'(ens), 32'h5);
    wr(12'h200, 32'h1, 4'hf);
    chk(32'(ens), 32'h7);
    wr(12'h110, 32'h0, 4'h4);
    rd(12'h110);
    chk(d, 32'h00000248);
    chk(32'(ens), 32'h1);
    acc(2'h0, 1'b0);
    acc(2'h1, 1'b1);
    acc(2'h2, 1'b1);
    sleep_active <= 1'b0;
    @(posedge mclk);
    chk(32'(ens), 32'h5);
    acc(2'h1, 1'b1);
    sleep_active <= 1'b1;
    $display("t_gating done");
  endtask
  task automatic t_rate;
    for (int c = 0; c < 3; c++) begin
      wr(12'h110, 32'(c) << 8, 4'hf);
      chk(32'(converter_rate_select), 32'(c));
    end
    $display("t_rate done");
  endtask
  task automatic t_unmapped;
    wr(12'h300, 32'hffffffff, 4'hf);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(12'h300);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    rd(12'h110);
    chk(d, 32'h00000240);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(12'h110);
    chk(d, 32'h00000040);
    $display("t_unmapped done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_gating;
    t_rate;
    t_unmapped;
    conclude;
  end
endmodule
